// File: src/port_ctl_defs.vh
`ifndef PORT_CTL_DEFS_VH
`define PORT_CTL_DEFS_VH

// word address of the control register (byte address 0x0, index 0)
`define CTL_ADDR          4'h0
// word address of the status register
`define STAT_ADDR         4'h1
`define ADDR_W            4

// field positions in the control word
`define DEBUG_MODE_BIT    8
`define DBG_REQ_BIT       9
`define LINK_NOTIFY_BIT   14
`define PARITY_IRQ_BIT    15
`define LIMIT_LO          16
`define LIMIT_HI          23

// reset values
`define RESET_LIMIT       8'h00
`define RESET_COUNT       8'h00
// retry counter step and saturation value
`define RETRY_STEP        8'h01
`define RETRY_MAX         8'hFF
`define ZERO_WORD         32'h0000_0000

// status register bits
`define STAT_PENDING_BIT  0
`define STAT_LOG_ERR_BIT  1
`define STAT_CNT_LO       8
`define STAT_CNT_HI       15

`endif

// File: src/retry_run_counter.v
`include "port_ctl_defs.vh"

// counts an unbroken run of retries; fires once when the limit is reached
module retry_run_counter (
  input  wire       core_clk_in,
  input  wire       reset_n_in,
  input  wire [7:0] limit_in,
  input  wire       retry_in,
  input  wire       accept_in,
  output wire [7:0] count_out,
  output wire       reached_out
);

  reg  [7:0] count_q;
  reg  [7:0] count_d;
  wire       enabled;
  wire       saturated;

  assign enabled   = (limit_in != `RESET_LIMIT);
  assign saturated = (count_q == `RETRY_MAX);

  always @*
  begin
    count_d = count_q;
    if (accept_in || !enabled)
      count_d = `RESET_COUNT; // RULE_08
    else if (retry_in && !saturated)
      count_d = count_q + `RETRY_STEP; // RULE_06
  end

  always @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      count_q <= `RESET_COUNT;
    else
      count_q <= count_d;
  end

  // fires only on the step onto the limit, so a long run reports once
  assign reached_out = enabled && (count_d == limit_in) && (count_q != limit_in); // RULE_07
  assign count_out   = count_q;

endmodule // retry_run_counter

// File: src/port_debug_notify_retry_ctl.v
// Notes on behaviour
// [RULE_01] debug mode unlocks capture writes, generator
// [RULE_02] request bit sends one packet, self-clears
// [RULE_03] writing request while pending does nothing
// [RULE_04] notify enable gates interrupt and port-write
// [RULE_05] parity enable gates lookup parity interrupt
// [RULE_06] retry run reaching limit: port-write, log error
// [RULE_07] limit zero disables retry reporting
// [RULE_08] accepted packet resets retry run counter
`include "port_ctl_defs.vh"

module port_debug_notify_retry_ctl (
  input  wire        core_clk_in,
  input  wire        reset_n_in,
  input  wire [3:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  input  wire        debug_packet_sent_in,
  input  wire        link_init_notify_event_in,
  input  wire        lookup_parity_error_in,
  input  wire        retry_received_in,
  input  wire        packet_accepted_in,
  input  wire        log_err_clear_in,
  output wire        capture_write_enable_out,
  output wire        debug_generator_enable_out,
  output reg         debug_packet_start_out,
  output reg         link_init_irq_out,
  output reg         link_init_port_write_out,
  output reg         lookup_parity_irq_out,
  output reg         retry_port_write_out,
  output wire        log_err_out
);

  reg        debug_mode_q;
  reg        debug_packet_request_q;
  reg        link_init_notify_enable_q;
  reg        lookup_parity_irq_enable_q;
  reg  [7:0] consecutive_retry_limit_q;
  reg        log_err_q;
  reg        ack_q;
  wire [7:0] retry_count;
  wire       retry_reached;
  wire       access;
  wire       wr_ctl;
  wire       set_request;
  reg  [31:0] rd_d;

  // one wait cycle per access: answer on the second edge
  assign access              = avs_read_in || avs_write_in;
  assign avs_waitrequest_out = access && !ack_q;
  assign wr_ctl = avs_write_in && ack_q && (avs_address_in == `CTL_ADDR);

  always @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      ack_q <= 1'b0;
    else
      ack_q <= access && !ack_q;
  end

  assign capture_write_enable_out   = debug_mode_q; // RULE_01
  assign debug_generator_enable_out = debug_mode_q; // RULE_01

  // request honoured only in debug mode and only when idle
  assign set_request = wr_ctl && avs_byteenable_in[1] && avs_writedata_in[`DBG_REQ_BIT]
                       && debug_mode_q && !debug_packet_request_q; // RULE_03

  always @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      debug_mode_q               <= 1'b0;
      link_init_notify_enable_q  <= 1'b0;
      lookup_parity_irq_enable_q <= 1'b0;
      consecutive_retry_limit_q  <= `RESET_LIMIT;
    end
    else if (wr_ctl)
    begin
      if (avs_byteenable_in[1])
      begin
        debug_mode_q               <= avs_writedata_in[`DEBUG_MODE_BIT];
        link_init_notify_enable_q  <= avs_writedata_in[`LINK_NOTIFY_BIT];
        lookup_parity_irq_enable_q <= avs_writedata_in[`PARITY_IRQ_BIT];
      end
      if (avs_byteenable_in[2])
        consecutive_retry_limit_q <= avs_writedata_in[`LIMIT_HI:`LIMIT_LO];
    end
  end

  always @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      debug_packet_request_q <= 1'b0;
      debug_packet_start_out <= 1'b0;
    end
    else
    begin
      debug_packet_start_out <= set_request; // RULE_02
      if (set_request)
        debug_packet_request_q <= 1'b1; // RULE_02
      else if (debug_packet_sent_in)
        debug_packet_request_q <= 1'b0; // RULE_02
    end
  end

  retry_run_counter retry_run_counter_i (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .limit_in    (consecutive_retry_limit_q),
    .retry_in    (retry_received_in),
    .accept_in   (packet_accepted_in),
    .count_out   (retry_count),
    .reached_out (retry_reached)
  );

  // events are registered pulses; log_err_q is a level held until log_err_clear_in
  always @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      link_init_irq_out        <= 1'b0;
      link_init_port_write_out <= 1'b0;
      lookup_parity_irq_out    <= 1'b0;
      retry_port_write_out     <= 1'b0;
      log_err_q                <= 1'b0;
    end
    else
    begin
      link_init_irq_out        <= link_init_notify_event_in && link_init_notify_enable_q; // RULE_04
      link_init_port_write_out <= link_init_notify_event_in && link_init_notify_enable_q; // RULE_04
      lookup_parity_irq_out    <= lookup_parity_error_in && lookup_parity_irq_enable_q; // RULE_05
      retry_port_write_out     <= retry_reached; // RULE_06
      // set wins over clear
      if (retry_reached)
        log_err_q <= 1'b1; // RULE_06
      else if (log_err_clear_in)
        log_err_q <= 1'b0;
    end
  end
  assign log_err_out = log_err_q;

  always @*
  begin
    rd_d = `ZERO_WORD;
    if (avs_address_in == `CTL_ADDR)
    begin
      rd_d[`DEBUG_MODE_BIT]        = debug_mode_q;
      rd_d[`DBG_REQ_BIT]           = debug_packet_request_q;
      rd_d[`LINK_NOTIFY_BIT]       = link_init_notify_enable_q;
      rd_d[`PARITY_IRQ_BIT]        = lookup_parity_irq_enable_q;
      rd_d[`LIMIT_HI:`LIMIT_LO]    = consecutive_retry_limit_q;
    end
    else if (avs_address_in == `STAT_ADDR)
    begin
      rd_d[`STAT_PENDING_BIT]      = debug_packet_request_q;
      rd_d[`STAT_LOG_ERR_BIT]      = log_err_q;
      rd_d[`STAT_CNT_HI:`STAT_CNT_LO] = retry_count;
    end
  end

  always @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      avs_readdata_out <= `ZERO_WORD;
    else if (avs_read_in && !ack_q)
      avs_readdata_out <= rd_d;
  end

endmodule // port_debug_notify_retry_ctl

// File: dv/port_ctl_sva.sv
module port_ctl_sva (
  input wire logic        core_clk_in,
  input wire logic        reset_n_in,
  input wire logic [3:0]  avs_address_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic        avs_waitrequest_out,
  input wire logic        capture_write_enable_out,
  input wire logic        debug_packet_start_out,
  input wire logic        link_init_notify_event_in,
  input wire logic        link_init_irq_out,
  input wire logic        link_init_port_write_out,
  input wire logic        lookup_parity_error_in,
  input wire logic        lookup_parity_irq_out,
  input wire logic        retry_received_in,
  input wire logic        retry_port_write_out,
  input wire logic        log_err_clear_in,
  input wire logic        log_err_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  wire logic hit = avs_write_in && !avs_waitrequest_out && avs_address_in == 4'h0;
  a_mode_on: assert property ($rose(capture_write_enable_out) |->
    $past(hit && avs_writedata_in[8])) else $error("mode set without write");
  a_req_start: assert property (debug_packet_start_out |->
    $past(hit && avs_writedata_in[9])) else $error("packet start without request");
  a_notify_pair: assert property (link_init_irq_out == link_init_port_write_out)
    else $error("notify irq and port write differ");
  a_notify_cause: assert property (link_init_irq_out |->
    $past(link_init_notify_event_in)) else $error("notify irq without event");
  a_parity_cause: assert property (lookup_parity_irq_out |->
    $past(lookup_parity_error_in)) else $error("parity irq without error");
  a_retry_log: assert property (retry_port_write_out |-> ##[0:1] log_err_out)
    else $error("retry report without log error");
  a_retry_cause: assert property (retry_port_write_out |->
    $past(retry_received_in) || $past(retry_received_in, 2)) else $error("report without retry");
  a_log_hold: assert property ($fell(log_err_out) |-> $past(log_err_clear_in))
    else $error("log error dropped without clear");
  c_start: cover property (debug_packet_start_out);
  c_notify: cover property (link_init_irq_out);
  c_retry: cover property (retry_port_write_out);
endmodule // port_ctl_sva

bind port_debug_notify_retry_ctl port_ctl_sva port_ctl_sva_i (
  .core_clk_in               (core_clk_in),
  .reset_n_in                (reset_n_in),
  .avs_address_in            (avs_address_in),
  .avs_write_in              (avs_write_in),
  .avs_writedata_in          (avs_writedata_in),
  .avs_waitrequest_out       (avs_waitrequest_out),
  .capture_write_enable_out  (capture_write_enable_out),
  .debug_packet_start_out    (debug_packet_start_out),
  .link_init_notify_event_in (link_init_notify_event_in),
  .link_init_irq_out         (link_init_irq_out),
  .link_init_port_write_out  (link_init_port_write_out),
  .lookup_parity_error_in    (lookup_parity_error_in),
  .lookup_parity_irq_out     (lookup_parity_irq_out),
  .retry_received_in         (retry_received_in),
  .retry_port_write_out      (retry_port_write_out),
  .log_err_clear_in          (log_err_clear_in),
  .log_err_out               (log_err_out)
);

// File: dv/port_debug_notify_retry_ctl_test.sv
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module port_debug_notify_retry_ctl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0;
  logic        rst_n = 0;
  logic [3:0]  addr = 4'h0;
  logic        rd_s = 0;
  logic        wr_s = 0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        wait_o;
  logic [5:0]  ev = 6'h00;
  logic        cap_en, gen_en, start, li_irq, li_pw, par_irq, rpw, log_err;
  int          fail_count = 0;
  int          n_checks = 0;
  int          n_start = 0, n_li = 0, n_par = 0, n_rpw = 0;
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    n_start += start;
    n_li += li_irq && li_pw;
    n_par += par_irq;
    n_rpw += rpw;
  end
  port_debug_notify_retry_ctl port_debug_notify_retry_ctl_i (
    .core_clk_in(clk), .reset_n_in(rst_n), .avs_address_in(addr), .avs_read_in(rd_s),
    .avs_write_in(wr_s), .avs_writedata_in(wdat), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wait_o), .debug_packet_sent_in(ev[0]),
    .link_init_notify_event_in(ev[1]), .lookup_parity_error_in(ev[2]),
    .retry_received_in(ev[3]), .packet_accepted_in(ev[4]), .log_err_clear_in(ev[5]),
    .capture_write_enable_out(cap_en), .debug_generator_enable_out(gen_en),
    .debug_packet_start_out(start), .link_init_irq_out(li_irq),
    .link_init_port_write_out(li_pw), .lookup_parity_irq_out(par_irq),
    .retry_port_write_out(rpw), .log_err_out(log_err));
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one Avalon access, held until waitrequest is seen low
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr_s <= w;
    rd_s <= !w;
    do
    begin
      @(posedge clk);
      i++;
    end while (wait_o !== 1'b0 && i < 8);
    if (wait_o !== 1'b0)
    begin
      fail_count++;
      summarize();
    end
    wr_s <= 0;
    rd_s <= 0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    acc(0, a, 32'h0000_0000);
    `CHK("readback", e, rdat)
  endtask
  // event pulse bits: sent, notify, parity, retry, accept, clear
  task automatic fire(input logic [5:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 6'h00;
    repeat (3) @(posedge clk);
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    rc(4'h0, 32'h0000_0000);
    rc(4'h1, 32'h0000_0000);
    acc(1, 4'h0, 32'h0003_C100);
    rc(4'h0, 32'h0003_C100);
    `CHK("capture", 1'b1, cap_en)
    `CHK("generator", 1'b1, gen_en)
    acc(1, 4'h0, 32'h0003_C300);
    rc(4'h1, 32'h0000_0001);
    acc(1, 4'h0, 32'h0003_C300);
    fire(6'h01);
    rc(4'h0, 32'h0003_C100);
    fire(6'h02);
    fire(6'h04);
    `CHK("notify", 1, n_li)
    `CHK("parity", 1, n_par)
    fire(6'h08);
    fire(6'h08);
    fire(6'h10);
    fire(6'h08);
    fire(6'h08);
    `CHK("early", 0, n_rpw)
    fire(6'h08);
    `CHK("limit", 1, n_rpw)
    `CHK("log set", 1'b1, log_err)
    rc(4'h1, 32'h0000_0302);
    fire(6'h20);
    `CHK("log clear", 1'b0, log_err)
    // leave debug mode first, so the request below must be refused
    acc(1, 4'h0, 32'h0000_0000);
    acc(1, 4'h0, 32'h0000_0200);
    rc(4'h0, 32'h0000_0000);
    `CHK("capture", 1'b0, cap_en)
    `CHK("generator", 1'b0, gen_en)
    repeat (4) fire(6'h0E);
    rc(4'h1, 32'h0000_0000);
    `CHK("quiet", 3, n_start + n_li + n_rpw)
    `CHK("parity", 1, n_par)
    rc(4'h7, 32'h0000_0000);
    summarize();
  end
endmodule // port_debug_notify_retry_ctl_test
